/* File: common/tef_defines.vh */
`ifndef TEF_DEFINES_VH
`define TEF_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define TEF_OFS_CTRL 8'h00
`define TEF_OFS_TOGGLE 8'h04
`define TEF_OFS_STATUS 8'h08
`define TEF_OFS_MASK 8'h0c
`define TEF_OFS_SNAP 8'h10
`define TEF_OFS_CMP0 8'h14
`define TEF_OFS_CMP1 8'h18

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TEF_CTRL_RUN 0
`define TEF_TGL_CMD_LO 0
`define TEF_TGL_CMD_HI 1
`define TEF_TGL_E0 2
`define TEF_TGL_E1 3
`define TEF_EV_C0 0
`define TEF_EV_C1 1
`define TEF_EV_OVF 2

// ---------------------------------------------------------------
// command codes and reset values
// ---------------------------------------------------------------
`define TEF_CMD_INVERT 2'h0
`define TEF_CMD_SET 2'h1
`define TEF_CMD_CLEAR 2'h2
`define TEF_CMD_KEEP 2'h3
`define TEF_TGL_RST 32'h000000c3
`define TEF_ZERO32 32'h00000000

`endif

/* File: core/tef_timer_events.v */
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "tef_defines.vh"

module tef_timer_events #(
    parameter CNT_W = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg timer_toggle_output_o,
    output reg irq_o
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg run_q;
    reg [CNT_W-1:0] live_count_value_q;
    reg [CNT_W-1:0] compare_value_zero_q;
    reg [CNT_W-1:0] compare_value_one_q;
    reg compare0_toggle_enable_q;
    reg compare1_toggle_enable_q;
    // one flop per flag lives in the generate loop; this is only their gathered view
    wire [2:0] event_status_q;
    reg [2:0] event_interrupt_mask_q;

    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i;
    wire rd = req & ~wb_we_i;
    wire wr_lo = wr & wb_sel_i[0];
    wire wr_hi = wr & wb_sel_i[1];

    // ---------------------------------------------------------------
    // counter and events
    // ---------------------------------------------------------------
    // match decoded on the present count so flag and toggle share one edge
    wire ev_c0 = run_q & (live_count_value_q == compare_value_zero_q);
    wire ev_c1 = run_q & (live_count_value_q == compare_value_one_q);
    wire ev_ovf = run_q & (&live_count_value_q);
    wire [2:0] ev_vec = {ev_ovf, ev_c1, ev_c0};

    always @(posedge clk_i) begin
        if (rst_i) begin
            live_count_value_q <= {CNT_W{1'b0}};
        end else if (run_q) begin
            live_count_value_q <= live_count_value_q + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
            compare_value_zero_q <= {CNT_W{1'b0}};
            compare_value_one_q <= {CNT_W{1'b0}};
            compare0_toggle_enable_q <= 1'b0;
            compare1_toggle_enable_q <= 1'b0;
            event_interrupt_mask_q <= 3'h0;
        end else begin
            if (wr_lo && wb_adr_i == `TEF_OFS_CTRL) begin
                run_q <= wb_dat_i[`TEF_CTRL_RUN];
            end
            if (wr_lo && wb_adr_i == `TEF_OFS_TOGGLE) begin
                compare0_toggle_enable_q <= wb_dat_i[`TEF_TGL_E0];
                compare1_toggle_enable_q <= wb_dat_i[`TEF_TGL_E1];
            end
            if (wr_lo && wb_adr_i == `TEF_OFS_MASK) begin
                event_interrupt_mask_q <= wb_dat_i[2:0];
            end
            if (wb_adr_i == `TEF_OFS_CMP0) begin
                if (wr_lo) compare_value_zero_q[7:0] <= wb_dat_i[7:0];
                if (wr_hi) compare_value_zero_q[15:8] <= wb_dat_i[15:8];
            end
            if (wb_adr_i == `TEF_OFS_CMP1) begin
                if (wr_lo) compare_value_one_q[7:0] <= wb_dat_i[7:0];
                if (wr_hi) compare_value_one_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // ---------------------------------------------------------------
    // timer flip-flop
    // ---------------------------------------------------------------
    // a software set, clear or invert command wins over a coincident match toggle; keep lets it through
    wire cmd_wr = wr_lo && (wb_adr_i == `TEF_OFS_TOGGLE);
    wire [1:0] cmd = wb_dat_i[`TEF_TGL_CMD_HI:`TEF_TGL_CMD_LO];
    wire hw_tgl = (ev_c0 & compare0_toggle_enable_q)
                ^ (ev_c1 & compare1_toggle_enable_q);

    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_toggle_output_o <= 1'b0;
        end else if (cmd_wr && cmd != `TEF_CMD_KEEP) begin
            case (cmd)
                `TEF_CMD_INVERT: timer_toggle_output_o <= ~timer_toggle_output_o;
                `TEF_CMD_SET: timer_toggle_output_o <= 1'b1;
                `TEF_CMD_CLEAR: timer_toggle_output_o <= 1'b0;
                default: timer_toggle_output_o <= timer_toggle_output_o;
            endcase
        end else if (hw_tgl) begin
            timer_toggle_output_o <= ~timer_toggle_output_o;
        end
    end

    // ---------------------------------------------------------------
    // status flags and interrupt
    // ---------------------------------------------------------------
    wire st_rd = rd && (wb_adr_i == `TEF_OFS_STATUS);
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
            // each flag owns its flop so no vector has several drivers
            reg flag_q;
            always @(posedge clk_i) begin
                if (rst_i) begin
                    flag_q <= 1'b0;
                end else if (ev_vec[gi]) begin
                    flag_q <= 1'b1;
                end else if (st_rd) begin
                    flag_q <= 1'b0;
                end
            end
            assign event_status_q[gi] = flag_q;
        end
    endgenerate

    // registered level; follows the flags one cycle later
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(event_status_q & ~event_interrupt_mask_q);
        end
    end

    // ---------------------------------------------------------------
    // bus answer: one wait-free cycle, ack the edge after the request
    // ---------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `TEF_ZERO32;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= `TEF_ZERO32;
            if (rd) begin
                case (wb_adr_i)
                    `TEF_OFS_CTRL: wb_dat_o <= {31'h0, run_q};
                    `TEF_OFS_TOGGLE: wb_dat_o <= `TEF_TGL_RST
                        | {28'h0, compare1_toggle_enable_q,
                           compare0_toggle_enable_q, 2'h0};
                    `TEF_OFS_STATUS: wb_dat_o <= {29'h0, event_status_q};
                    `TEF_OFS_MASK: wb_dat_o <= {29'h0, event_interrupt_mask_q};
                    `TEF_OFS_SNAP: wb_dat_o <= {16'h0, live_count_value_q};
                    `TEF_OFS_CMP0: wb_dat_o <= {16'h0, compare_value_zero_q};
                    `TEF_OFS_CMP1: wb_dat_o <= {16'h0, compare_value_one_q};
                    default: wb_dat_o <= `TEF_ZERO32;
                endcase
            end
        end
    end

endmodule // tef_timer_events
`default_nettype wire

/* File: verif/tb_tef_timer_events.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_tef_timer_events;
    logic clk = 1'b0, rst = 1'b1, rq = 1'b0, we = 1'b0, ex = 1'b0, ack, tgl, irq;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, dato, rd, s;
    logic [2:0] m;
    integer seed = 78, miscompares = 0, check_count = 0, i;
    tef_timer_events dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(rq), .wb_stb_i(rq),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wd), .wb_dat_o(dato),
        .wb_ack_o(ack), .timer_toggle_output_o(tgl), .irq_o(irq));
    initial forever #4 clk = ~clk;
    initial begin
        #700000 miscompares++;
        stop_test;
    end
    function logic nxt(input logic [1:0] c, input logic o);
        return c == 2'h1 ? 1'b1 : c == 2'h2 ? 1'b0 : c == 2'h0 ? ~o : o;
    endfunction
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        rq <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (ack !== 1'b1); // watchdog bounds this
        rd = dato;
        rq <= 1'b0;
        @(posedge clk);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, 8'h1c, '0);
        `CHK("unmapped", 32'h0, rd)
        for (i = 0; i < 5; i++) begin
            m = (i == 0) ? 3'h7 : 3'($random(seed));
            bus(1'b0, 8'h10, '0);
            s = rd + 32'd40 + 32'($random(seed) & 15);
            bus(1'b1, 8'h14, s);
            bus(1'b1, 8'h18, s + 32'd30);
            bus(1'b1, 8'h0c, {29'h0, m});
            bus(1'b1, 8'h04, {28'h0, i[1:0], i[1:0] ^ 2'h1});
            ex = nxt(i[1:0] ^ 2'h1, ex);
            `CHK("cmd", ex, tgl)
            bus(1'b1, 8'h00, 32'h1);
            bus(1'b0, 8'h10, '0);
            s = rd;
            bus(1'b0, 8'h10, '0);
            `CHK("live", s + 32'd3, rd)
            repeat ((i == 4) ? 65540 : 90) @(posedge clk);
            bus(1'b1, 8'h00, '0);
            ex = ex ^ i[0] ^ i[1];
            `CHK("match", ex, tgl)
            `CHK("irq", |({i == 4, 2'h3} & ~m), irq)
            bus(1'b0, 8'h08, '0);
            `CHK("flags", {29'h0, i == 4, 2'h3}, rd)
            bus(1'b0, 8'h08, '0);
            `CHK("clear", 32'h0, rd)
        end
        stop_test;
    end
endmodule // tb_tef_timer_events
`default_nettype wire

/* File: verif/tef_timer_events_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module tef_timer_events_chk (
    input wire clk_i, input wire rst_i, input wire wb_cyc_i, input wire wb_stb_i,
    input wire wb_we_i, input wire [7:0] wb_adr_i, input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i, input wire [31:0] wb_dat_o, input wire wb_ack_o,
    input wire timer_toggle_output_o, input wire irq_o
);
    wire rq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire rc = rq & ~wb_we_i;
    wire wt = rq & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'h04);
    wire mw = rq & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'h0c);
    wire tq = timer_toggle_output_o;
    reg [2:0] m_q; // mask as software wrote it, the irq is judged against it
    always @(posedge clk_i) m_q <= rst_i ? 3'h0 : (mw ? wb_dat_i[2:0] : m_q);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; rq |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("data outside ack");
    property p_set; wt && wb_dat_i[1:0] == 2'h1 |=> tq; endproperty
    a_set: assert property (p_set) else $error("set cmd");
    property p_clr; wt && wb_dat_i[1:0] == 2'h2 |=> !tq; endproperty
    a_clr: assert property (p_clr) else $error("clear cmd");
    property p_inv; wt && wb_dat_i[1:0] == 2'h0 |=> tq != $past(tq); endproperty
    a_inv: assert property (p_inv) else $error("invert cmd");
    property p_cmd; rc && wb_adr_i == 8'h04 |=>
        wb_dat_o[31:6] == 26'h3 && wb_dat_o[1:0] == 2'h3; endproperty
    a_cmd: assert property (p_cmd) else $error("cmd readback");
    property p_msk; rc && wb_adr_i == 8'h0c |=> wb_dat_o == {29'h0, m_q}; endproperty
    a_msk: assert property (p_msk) else $error("mask readback");
    property p_irq; (m_q == 3'h7) [*2] |-> !irq_o; endproperty
    a_irq: assert property (p_irq) else $error("masked irq");
    c_irq: cover property ($rose(irq_o));
    c_inv: cover property (wt && wb_dat_i[1:0] == 2'h0);
    c_msk: cover property ((m_q == 3'h7) [*2]);
endmodule // tef_timer_events_chk
bind tef_timer_events tef_timer_events_chk u_chk (.*);
`default_nettype wire
